// [inc/scan_seq_defines.vh]
// Constants for the host-controlled touch scan sequencer.
//
// Overview of operation
// - In host-controlled scan mode a panel touch raises the pen-touch flag and pulls the shared interrupt pin low when it is set to the pen interrupt function.
// - A coordinate request made while the panel drivers are off makes the block turn the drivers on itself before the scan.
// - An X or Y conversion with drivers on takes the first overhead, precharge, sense and 6 overhead cycles, N samples of B+2 converter clocks plus overhead, then the preprocessing delay.
// - A pressure conversion with drivers on has the same structure but uses the second, longer initial overhead and runs samples and preprocessing twice.
// - With the drivers off before the command, the programmed stabilization time and its larger overhead come before precharge and sense.
// - Function code 0101 starts one auxiliary measurement and code 1000 starts a repeating auxiliary measurement.
// - Function code 0110 starts the first temperature measurement and code 0111 the second.
// - Both temperature measurements use the sequencing and timing of the single auxiliary measurement.
// - A single auxiliary or temperature measurement has no drive, precharge or sense phase and takes 3.5 overhead cycles, N samples and the preprocessing delay.
// - The first initial overhead is 2.5 oscillator cycles.
// - The second initial overhead is 3.5 oscillator cycles.
// - Each converter sample adds 3 oscillator cycles beyond its converter clock count.
`ifndef SCAN_SEQ_DEFINES_VH
`define SCAN_SEQ_DEFINES_VH
// Half-cycle units of the oscillator: 2.5 -> 5, 3.5 -> 7.
`define OH1_HALF        8'h05
`define OH2_HALF        8'h07
`define OH3_HALF        8'h07
`define OH_DLY1_HALF    8'h14
`define OH_DLY2_HALF    8'h0C
`define OH_CONV_HALF    8'h06
// Converter clocks per sample: B+2 with B fixed at 12.
`define CONV_CLKS       5'h0E
// Function codes.
`define FN_X            4'h2
`define FN_Y            4'h3
`define FN_Z            4'h4
`define FN_AUX_ONE      4'h5
`define FN_TEMPERATURE_MEASURE_FIRST        4'h6
`define FN_TEMPERATURE_MEASURE_SECOND        4'h7
`define FN_AUX_CONT     4'h8
`define FN_DRV_X        4'h9
`define FN_DRV_Y        4'hA
`define FN_DRV_Z        4'hB
// APB register offsets.
`define REG_CTRL        8'h00
`define REG_TIMING      8'h04
`define REG_STATUS      8'h08
`define REG_CLEAR       8'h0C
`define REG_ENABLE      8'h10
`define REG_RES_X       8'h14
`define REG_RES_Y       8'h18
`define REG_RES_Z1      8'h1C
`define REG_RES_Z2      8'h20
`define REG_RES_AUX     8'h24
`define REG_RES_TEMPERATURE_MEASURE_FIRST   8'h28
`define REG_RES_TEMPERATURE_MEASURE_SECOND   8'h2C
// Control and status field positions and reset values.
`define CTRL_FN_LSB     0
`define CTRL_MODE_BIT   4
`define CTRL_PENFN_BIT  5
`define CTRL_RESET      32'h0000_0030
`define TIMING_RESET    32'h0002_0411
`define STAT_PEN        0
`define STAT_DONE       1
`define STAT_W          2
`endif

// [hdl/scan_seq.v]
// Host-controlled touch scan and auxiliary measurement sequencer with APB registers.
`timescale 1ns/100ps
`include "scan_seq_defines.vh"
module scan_seq
(
  input  wire        sys_clk,        // System clock, 10 MHz
  input  wire        sys_rst,        // Synchronous reset, active high
  input  wire        psel,           // APB select
  input  wire        penable,        // APB enable
  input  wire        pwrite,         // APB write
  input  wire [7:0]  paddr,          // APB byte address
  input  wire [31:0] pwdata,         // APB write data
  output reg  [31:0] prdata,         // APB read data
  output reg         pready,         // APB ready
  output reg         pslverr,        // APB error
  input  wire        osc_clk,        // Internal oscillator, sampled
  input  wire        adc_clk,        // Converter clock, sampled
  input  wire        pen_touch_in,   // Panel touch detect, raw
  input  wire [11:0] adc_data,       // Converter sample
  output reg         adc_sample,     // Converter sample strobe
  output reg  [1:0]  drv_sel,        // Drivers on: 0 off, 1 X, 2 Y, 3 Z
  output reg         pen_irq_data_avail_pin_n, // Shared interrupt pin, active low
  output reg         irq             // Level interrupt
);

  // ------------------------------------------------------------
  // Synchronisers and edge detection
  // ------------------------------------------------------------
  reg [2:0] osc_s_r;
  reg [2:0] adc_s_r;
  reg [1:0] pen_s_r;
  reg [11:0] adc_d1_r;
  reg [11:0] adc_d2_r;
  wire      osc_edge = osc_s_r[1] ^ osc_s_r[2];
  wire      adc_rise = adc_s_r[1] & ~adc_s_r[2];
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      osc_s_r  <= 3'h0;
      adc_s_r  <= 3'h0;
      pen_s_r  <= 2'h0;
      adc_d1_r <= 12'h000;
      adc_d2_r <= 12'h000;
    end
    else
    begin
      osc_s_r  <= {osc_s_r[1:0], osc_clk};
      adc_s_r  <= {adc_s_r[1:0], adc_clk};
      pen_s_r  <= {pen_s_r[0], pen_touch_in};
      adc_d1_r <= adc_data;
      adc_d2_r <= adc_d1_r;
    end
  end
  wire pen_now = pen_s_r[1];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg  [31:0] ctrl_r;
  reg  [31:0] timing_r;
  reg  [`STAT_W-1:0] status_r;
  reg  [`STAT_W-1:0] enable_r;
  reg  [11:0] res_r [0:6];
  wire        host_mode = ctrl_r[`CTRL_MODE_BIT];
  wire        pen_fn = ctrl_r[`CTRL_PENFN_BIT];
  wire [7:0]  t_pvs  = timing_r[7:0];
  wire [7:0]  t_pre  = timing_r[15:8];
  wire [3:0]  t_sns  = timing_r[19:16];
  wire [3:0]  n_samp = timing_r[23:20];
  wire [7:0]  l_ppro = timing_r[31:24];
  wire        apb_acc = psel & penable & pready;
  wire        apb_wr  = apb_acc & pwrite;
  wire        start_wr = apb_wr && (paddr == `REG_CTRL);
  reg         done_ev;
  reg         done_set;
  reg [2:0]   res_idx_r;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_OH   = 3'd1;
  localparam ST_PVS  = 3'd2;
  localparam ST_PRE  = 3'd3;
  localparam ST_CONV = 3'd4;
  localparam ST_PPRO = 3'd5;
  reg [2:0]  st_r;
  reg [8:0]  cnt_r;
  reg [3:0]  nleft_r;
  reg [4:0]  clk_left_r;
  reg [15:0] acc_r;
  reg [11:0] res_val_r;
  reg        z_second_r;
  reg        cont_r;
  reg        drvon_r;
  reg [3:0]  job_r;
  reg        sense_r;

  // Half-cycle counting: every oscillator edge is half a cycle.
  wire tick = osc_edge;
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_r       <= ST_IDLE;
      cnt_r      <= 9'h000;
      nleft_r    <= 4'h0;
      clk_left_r <= 5'h00;
      acc_r      <= 16'h0000;
      res_val_r  <= 12'h000;
      z_second_r <= 1'b0;
      cont_r     <= 1'b0;
      drvon_r    <= 1'b0;
      job_r      <= 4'h0;
      sense_r    <= 1'b0;
      drv_sel    <= 2'h0;
      adc_sample <= 1'b0;
      done_ev    <= 1'b0;
      res_idx_r  <= 3'h0;
    end
    else
    begin
      adc_sample <= 1'b0;
      done_ev    <= 1'b0;
      case (st_r)
        ST_IDLE:
        begin
          if (start_wr && pwdata[`CTRL_MODE_BIT])
          begin
            job_r <= pwdata[3:0];
            z_second_r <= 1'b0;
            cont_r <= (pwdata[3:0] == `FN_AUX_CONT);
            case (pwdata[3:0])
              `FN_DRV_X: drv_sel <= 2'h1;
              `FN_DRV_Y: drv_sel <= 2'h2;
              `FN_DRV_Z: drv_sel <= 2'h3;
              `FN_X, `FN_Y, `FN_Z:
              begin
                // Drivers left off are switched on by the block itself.
                drvon_r <= (drv_sel != 2'h0);
                drv_sel <= (pwdata[3:0] == `FN_X) ? 2'h1 :
                           (pwdata[3:0] == `FN_Y) ? 2'h2 : 2'h3;
                sense_r <= 1'b1;
                cnt_r <= (pwdata[3:0] == `FN_Z || drv_sel == 2'h0) ?
                         {1'b0, `OH2_HALF} : {1'b0, `OH1_HALF};
                st_r <= ST_OH;
              end
              `FN_AUX_ONE, `FN_TEMPERATURE_MEASURE_FIRST, `FN_TEMPERATURE_MEASURE_SECOND, `FN_AUX_CONT:
              begin
                // No panel drive during auxiliary and temperature measurements.
                drv_sel <= 2'h0;
                sense_r <= 1'b0;
                cnt_r <= {1'b0, `OH3_HALF};
                st_r <= ST_OH;
              end
              default: drv_sel <= 2'h0;
            endcase
          end
        end
        ST_OH:
        begin
          if (tick)
          begin
            if (cnt_r <= 9'h001)
            begin
              if (!sense_r)
              begin
                nleft_r <= n_samp;
                acc_r <= 16'h0000;
                clk_left_r <= `CONV_CLKS;
                st_r <= ST_CONV;
              end
              else if (!drvon_r)
              begin
                cnt_r <= {t_pvs, 1'b0} + {1'b0, `OH_DLY1_HALF};
                st_r <= ST_PVS;
              end
              else
              begin
                cnt_r <= {t_pre, 1'b0} + {4'h0, t_sns, 1'b0} + {1'b0, `OH_DLY2_HALF};
                st_r <= ST_PRE;
              end
            end
            else
              cnt_r <= cnt_r - 9'h001;
          end
        end
        ST_PVS:
        begin
          if (tick)
          begin
            if (cnt_r <= 9'h001)
            begin
              // Stabilization overhead already covers precharge and sense overhead.
              cnt_r <= {t_pre, 1'b0} + {4'h0, t_sns, 1'b0};
              st_r <= ST_PRE;
            end
            else
              cnt_r <= cnt_r - 9'h001;
          end
        end
        ST_PRE:
        begin
          if (tick)
          begin
            if (cnt_r <= 9'h001)
            begin
              nleft_r <= n_samp;
              acc_r <= 16'h0000;
              clk_left_r <= `CONV_CLKS;
              st_r <= ST_CONV;
            end
            else
              cnt_r <= cnt_r - 9'h001;
          end
        end
        ST_CONV:
        begin
          // B+2 converter clocks, then the per-sample overhead on the oscillator.
          if (clk_left_r != 5'h00)
          begin
            if (adc_rise)
            begin
              clk_left_r <= clk_left_r - 5'h01;
              if (clk_left_r == 5'h01)
              begin
                adc_sample <= 1'b1;
                acc_r <= acc_r + {4'h0, adc_d2_r};
                cnt_r <= {1'b0, `OH_CONV_HALF};
              end
            end
          end
          else if (tick)
          begin
            if (cnt_r <= 9'h001)
            begin
              if (nleft_r <= 4'h1)
              begin
                cnt_r <= {l_ppro, 1'b0};
                st_r <= ST_PPRO;
              end
              else
              begin
                nleft_r <= nleft_r - 4'h1;
                clk_left_r <= `CONV_CLKS;
              end
            end
            else
              cnt_r <= cnt_r - 9'h001;
          end
        end
        ST_PPRO:
        begin
          if (tick)
          begin
            if (cnt_r <= 9'h001)
            begin
              done_ev <= 1'b1;
              res_val_r <= acc_r[11:0];
              res_idx_r <= (job_r == `FN_X) ? 3'd0 : (job_r == `FN_Y) ? 3'd1 :
                           (job_r == `FN_Z) ? (z_second_r ? 3'd3 : 3'd2) :
                           (job_r == `FN_TEMPERATURE_MEASURE_FIRST) ? 3'd5 :
                           (job_r == `FN_TEMPERATURE_MEASURE_SECOND) ? 3'd6 : 3'd4;
              if (job_r == `FN_Z && !z_second_r)
              begin
                z_second_r <= 1'b1;
                nleft_r <= n_samp;
                acc_r <= 16'h0000;
                clk_left_r <= `CONV_CLKS;
                st_r <= ST_CONV;
              end
              else if (cont_r && host_mode)
              begin
                cnt_r <= {1'b0, `OH3_HALF};
                st_r <= ST_OH;
              end
              else
                st_r <= ST_IDLE;
            end
            else
              cnt_r <= cnt_r - 9'h001;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Results, status and interrupt
  // ------------------------------------------------------------
  // The sum is held, so the restart for the second pressure value cannot clear it first.
  wire [11:0] result = res_val_r;
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_res
      always @(posedge sys_clk)
      begin
        if (sys_rst)
          res_r[gi] <= 12'h000;
        else if (done_ev && res_idx_r == gi)
          res_r[gi] <= result;
      end
    end
  endgenerate
  wire [`STAT_W-1:0] ev = {done_ev, pen_now & host_mode};
  wire [`STAT_W-1:0] clr = (apb_wr && paddr == `REG_CLEAR) ? pwdata[`STAT_W-1:0] : 2'h0;
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl_r   <= `CTRL_RESET;
      timing_r <= `TIMING_RESET;
      status_r <= 2'h0;
      enable_r <= 2'h0;
      irq      <= 1'b0;
      pen_irq_data_avail_pin_n <= 1'b1;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end
    else
    begin
      status_r <= (status_r & ~clr) | ev;
      irq <= |(status_r & enable_r);
      // Pin: pen touch when set to the pen function, else data available.
      pen_irq_data_avail_pin_n <= pen_fn ? ~(pen_now & host_mode) : ~status_r[`STAT_DONE];
      pready  <= psel & ~pready;
      pslverr <= 1'b0;
      // Writes land at the edge that completes the access; read data is loaded one cycle earlier.
      if (apb_wr && paddr == `REG_CTRL)
        ctrl_r <= pwdata;
      if (apb_wr && paddr == `REG_TIMING)
        timing_r <= pwdata;
      if (apb_wr && paddr == `REG_ENABLE)
        enable_r <= pwdata[`STAT_W-1:0];
      if (psel && !pready)
      begin
        case (paddr)
          `REG_CTRL:      prdata <= ctrl_r;
          `REG_TIMING:    prdata <= timing_r;
          `REG_STATUS:    prdata <= {30'h0, status_r};
          `REG_CLEAR:     prdata <= 32'h0000_0000;
          `REG_ENABLE:    prdata <= {30'h0, enable_r};
          `REG_RES_X:     prdata <= {20'h0, res_r[0]};
          `REG_RES_Y:     prdata <= {20'h0, res_r[1]};
          `REG_RES_Z1:    prdata <= {20'h0, res_r[2]};
          `REG_RES_Z2:    prdata <= {20'h0, res_r[3]};
          `REG_RES_AUX:   prdata <= {20'h0, res_r[4]};
          `REG_RES_TEMPERATURE_MEASURE_FIRST: prdata <= {20'h0, res_r[5]};
          `REG_RES_TEMPERATURE_MEASURE_SECOND: prdata <= {20'h0, res_r[6]};
          default:
          begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// [tb/scan_seq_properties.sv]
// Port assertions for the touch scan sequencer.
`timescale 1ns/100ps
module scan_seq_checker
(
  input wire        sys_clk,      // Clock.
  input wire        sys_rst,      // Reset.
  input wire        psel,         // Select.
  input wire        penable,      // Enable.
  input wire        pwrite,       // Write.
  input wire [7:0]  paddr,        // Address.
  input wire [31:0] pwdata,       // Write data.
  input wire        pready,       // Ready.
  input wire        pslverr,      // Error.
  input wire        pen_touch_in, // Touch.
  input wire        adc_sample,   // Strobe.
  input wire [1:0]  drv_sel,      // Drivers.
  input wire        pen_irq_data_avail_pin_n, // Pin.
  input wire        irq           // Interrupt.
);
  reg [5:0] ctrl_r;
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      ctrl_r <= 6'h30;
    else if (psel && penable && pready && pwrite && paddr == 8'h00)
      ctrl_r <= pwdata[5:0];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_x_cold;
    psel && penable && pready && pwrite && paddr == 8'h00
      && pwdata[4:0] == 5'h12 && drv_sel == 2'h0;
  endsequence
  property p_apb_ready;
    s_setup |=> pready && penable;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_pen_pin;
    (ctrl_r[5] && ctrl_r[4] && pen_touch_in) [*6] |-> !pen_irq_data_avail_pin_n;
  endproperty
  a_pen_pin: assert property (p_pen_pin) else $error("pin not low on touch");
  property p_auto_drive;
    s_x_cold |-> ##[1:100] drv_sel == 2'h1;
  endproperty
  a_auto_drive: assert property (p_auto_drive) else $error("drivers not enabled");
  property p_coord_drive;
    adc_sample && ctrl_r[3:0] inside {4'h2, 4'h3, 4'h4} |-> drv_sel == ctrl_r[1:0] - 2'h1;
  endproperty
  a_coord_drive: assert property (p_coord_drive) else $error("wrong drivers");
  property p_aux_nodrive;
    adc_sample && ctrl_r[3:0] inside {[4'h5:4'h8]} |-> drv_sel == 2'h0;
  endproperty
  a_aux_nodrive: assert property (p_aux_nodrive) else $error("panel driven");
  property p_sample_gap;
    adc_sample |=> !adc_sample [*8];
  endproperty
  a_sample_gap: assert property (p_sample_gap) else $error("samples too close");
  property p_reset_idle;
    $fell(sys_rst) |-> drv_sel == 2'h0 && !irq && pen_irq_data_avail_pin_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
endmodule
bind scan_seq scan_seq_checker u_chk
(
  .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .pen_touch_in(pen_touch_in), .adc_sample(adc_sample), .drv_sel(drv_sel),
  .pen_irq_data_avail_pin_n(pen_irq_data_avail_pin_n), .irq(irq)
);

// [tb/panel_model.sv]
// Far-side model: oscillator, converter clock, sample data and panel touch.
`timescale 1ns/100ps
module panel_model
(
  output logic        osc_clk,      // Oscillator.
  output logic        adc_clk,      // Converter clock.
  output logic [11:0] adc_data,     // Sample value.
  output logic        pen_touch_in, // Touch detect.
  input  logic        touch,        // Touch request.
  input  logic [11:0] value         // Value to convert.
);
  // Both clocks run free with odd offsets so their edges never coincide with a system clock edge.
  initial
  begin
    osc_clk = 1'h0;
    #37;
    forever #400 osc_clk = ~osc_clk;
  end
  initial
  begin
    adc_clk = 1'h0;
    #13;
    forever #100 adc_clk = ~adc_clk;
  end
  assign adc_data     = value;
  assign pen_touch_in = touch;
endmodule

// [tb/scan_seq_tb.sv]
// Self-checking bench for the touch scan sequencer.
`timescale 1ns/100ps
module scan_seq_tb;
  localparam int HALF = 4;
  localparam int SAMP = 28;
  logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic        osc_clk, adc_clk, pen_touch_in, adc_sample, irq, pin_n, touch, loose;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [11:0] adc_data, value;
  logic [1:0]  drv_sel;
  logic [1:0]  exp_q[$];
  int          failures, tests_run, cyc, nsamp, t, n, n0;
  scan_seq u_dut
  (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_clk(osc_clk), .adc_clk(adc_clk), .pen_touch_in(pen_touch_in), .adc_data(adc_data),
    .adc_sample(adc_sample), .drv_sel(drv_sel), .pen_irq_data_avail_pin_n(pin_n), .irq(irq)
  );
  panel_model u_panel
  (
    .osc_clk(osc_clk), .adc_clk(adc_clk), .adc_data(adc_data),
    .pen_touch_in(pen_touch_in), .touch(touch), .value(value)
  );
  always #50 sys_clk = ~sys_clk;
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do
      @(posedge sys_clk);
    while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rdat, e);
  endtask
  // Starts one command, waits for each done interrupt and checks the first one's duration when lo is above zero.
  task automatic run(input logic [3:0] fn, input logic [1:0] drv, input int ns, input int lo);
    value <= 12'($urandom);
    repeat (ns) exp_q.push_back(drv);
    apb(1'h1, 8'h00, {26'h0, 2'h3, fn});
    // One done event per result; a pressure command gives two.
    repeat (ns)
    begin
      t = 0;
      while (irq !== 1'h1 && t < 2000)
      begin
        @(posedge sys_clk);
        t++;
      end
      chk(32'(irq), 32'h1);
      if (lo > 0)
        chk(32'(t >= lo - 8 && t <= lo + 24), 32'h1);
      lo = 0;
      apb(1'h1, 8'h0C, 32'h2);
      repeat (2) @(posedge sys_clk);
    end
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (adc_sample === 1'h1)
    begin
      nsamp++;
      if (exp_q.size() > 0)
        chk(drv_sel, exp_q.pop_front());
      else if (!loose)
        chk(32'h0, 32'h1);
    end
    if (cyc == 50000)
    begin
      failures++;
      stop_test();
    end
  end
  initial
  begin
    sys_clk = 1'h0;
    sys_rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    touch = 1'h0;
    value = 12'h000;
    loose = 1'h0;
    void'($urandom(67671));
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'h0;
    rd(8'h00, 32'h30);
    rd(8'h04, 32'h0002_0411);
    rd(8'h40, 32'h0);
    chk(rerr, 1'h1);
    apb(1'h1, 8'h04, 32'h0210_0002);
    apb(1'h1, 8'h10, 32'h2);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'h1, 8'h00, 32'h39 + i);
      repeat (20) @(posedge sys_clk);
      chk(drv_sel, i + 1);
      run(4'h2 + i, i + 1, (i == 2) ? 2 : 1, (i == 2) ? 0 : HALF * 27 + SAMP);
      rd(8'h14 + 4 * i, value);
    end
    rd(8'h20, value);
    apb(1'h1, 8'h00, 32'h30);
    repeat (8) @(posedge sys_clk);
    chk(drv_sel, 2'h0);
    run(4'h2, 2'h1, 1, HALF * 41 + SAMP);
    rd(8'h14, value);
    for (int i = 0; i < 3; i++)
    begin
      run(4'h5 + i, 2'h0, 1, HALF * 17 + SAMP);
      rd(8'h24 + 4 * i, value);
    end
    repeat (3) exp_q.push_back(2'h0);
    apb(1'h1, 8'h00, 32'h38);
    n = 0;
    while (exp_q.size() > 0 && n < 2000)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(exp_q.size(), 0);
    loose = 1'h1;
    apb(1'h1, 8'h00, 32'h20);
    repeat (300) @(posedge sys_clk);
    loose = 1'h0;
    n0 = nsamp;
    repeat (300) @(posedge sys_clk);
    chk(nsamp, n0);
    rd(8'h08, 32'h2);
    chk(irq, 1'h1);
    apb(1'h1, 8'h10, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'h0);
    apb(1'h1, 8'h0C, 32'h2);
    rd(8'h08, 32'h0);
    apb(1'h1, 8'h10, 32'h1);
    apb(1'h1, 8'h00, 32'h30);
    touch <= 1'h1;
    repeat (12) @(posedge sys_clk);
    chk(pin_n, 1'h0);
    chk(irq, 1'h1);
    rd(8'h08, 32'h1);
    apb(1'h1, 8'h00, 32'h10);
    repeat (4) @(posedge sys_clk);
    chk(pin_n, 1'h1);
    touch <= 1'h0;
    repeat (12) @(posedge sys_clk);
    apb(1'h1, 8'h0C, 32'h1);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'h0);
    stop_test();
  end
endmodule
